// ### bls_defs.svh
// Functional notes
// - and/or/xor destination with register or immediate
// - complement inverts destination register byte
// - arithmetic shifts write back same register
// - logical shifts write back same register
// - plain rotates recirculate the outgoing bit
// - rotates via carry form nine-bit ring
// - force one sets selected bit only
// - force zero clears selected bit only
// - toggle inverts selected bit only
// - probe sets zero to inverted bit
// - bit number from immediate or register
// - inverted carry ops use immediate bit only
// - carry becomes carry and bit
// - carry becomes carry and inverted bit
// - carry becomes carry or bit
// - carry becomes carry or inverted bit
// - carry becomes carry xor bit
// - carry becomes carry xor inverted bit
// - carry loaded from selected bit
// - carry loaded from inverted bit
// - carry stored into selected bit
// - inverted carry stored into selected bit
`ifndef BLS_DEFS_SVH
`define BLS_DEFS_SVH
`define BLS_DATA_W 8
`define BLS_BIT_W 3
`define BLS_IDX_W 3
`define BLS_REG_CNT 8
`define BLS_ADDR_W 16
`define BLS_BYTE_RST 8'h00
`define BLS_ADDR_RST 16'h0000
`define BLS_CARRY_RST 1'b0
`define BLS_ZERO_RST 1'b0
`endif

// ### bls_pkg.sv
package bls_pkg;
  typedef enum logic [4:0] {
    op_and, op_or, op_xor, op_not,
    op_arith_left_shift, op_arith_right_shift,
    op_logic_left_shift, op_logic_right_shift,
    op_rotate_left_plain, op_rotate_right_plain,
    op_rotate_left_via_carry, op_rotate_right_via_carry,
    op_single_bit_force_one, op_single_bit_force_zero,
    op_single_bit_toggle, op_single_bit_probe,
    op_carry_and_bit, op_carry_and_inverted_bit,
    op_carry_or_bit, op_carry_or_inverted_bit,
    op_carry_xor_bit, op_carry_xor_inverted_bit,
    op_carry_load_from_bit, op_carry_load_inverted_bit,
    op_carry_store_to_bit, op_carry_store_inverted
  } bls_op_t;

  typedef enum logic [2:0] {
    st_idle, st_reg_read, st_mem_read, st_execute, st_mem_write
  } bls_state_t;
endpackage : bls_pkg

// ### bls_gpr_file.sv
`timescale 1ns/10ps
`include "bls_defs.svh"
module bls_gpr_file
  import bls_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // read ports
  input wire logic [`BLS_IDX_W-1:0] rd_a_idx,
  input wire logic [`BLS_IDX_W-1:0] rd_b_idx,
  output logic [`BLS_DATA_W-1:0] rd_a_data,
  output logic [`BLS_DATA_W-1:0] rd_b_data,
  // write port
  input wire logic wr_en,
  input wire logic [`BLS_IDX_W-1:0] wr_idx,
  input wire logic [`BLS_DATA_W-1:0] wr_data
);
  logic [`BLS_DATA_W-1:0] mem_array [`BLS_REG_CNT];

  // ************************************
  // storage
  // ************************************
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem_array[wr_idx] <= wr_data;
    end
  end

  // ************************************
  // registered read data
  // ************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_a_data <= `BLS_BYTE_RST;
      rd_b_data <= `BLS_BYTE_RST;
    end
    else
    begin
      rd_a_data <= mem_array[rd_a_idx];
      rd_b_data <= mem_array[rd_b_idx];
    end
  end
endmodule : bls_gpr_file

// ### bls_unit.sv
`timescale 1ns/10ps
`include "bls_defs.svh"
module bls_unit
  import bls_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bls_op_t cmd_op,
  input wire logic [`BLS_IDX_W-1:0] cmd_dst_idx,
  input wire logic [`BLS_IDX_W-1:0] cmd_src_idx,
  input wire logic cmd_use_imm,
  input wire logic [`BLS_DATA_W-1:0] cmd_imm,
  input wire logic [`BLS_BIT_W-1:0] cmd_bit_imm,
  input wire logic cmd_bit_from_reg,
  input wire logic cmd_to_mem,
  input wire logic [`BLS_ADDR_W-1:0] cmd_mem_addr,
  // completion
  output logic done,
  output logic [`BLS_DATA_W-1:0] result_data,
  // flags
  input wire logic flag_load,
  input wire logic flag_c_load_val,
  input wire logic flag_z_load_val,
  output logic carry_flag,
  output logic zero_flag,
  // memory byte access
  output logic mem_rd_req,
  output logic mem_wr_req,
  output logic [`BLS_ADDR_W-1:0] mem_addr,
  output logic [`BLS_DATA_W-1:0] mem_wdata,
  input wire logic [`BLS_DATA_W-1:0] mem_rdata,
  input wire logic mem_rdy
);
  // ************************************
  // helpers
  // ************************************
  function automatic logic [`BLS_DATA_W-1:0] bit_mask(
    input logic [`BLS_BIT_W-1:0] n);
    bit_mask = `BLS_DATA_W'(1) << n;
  endfunction : bit_mask

  function automatic logic is_bit_op(input bls_op_t op);
    is_bit_op = (op >= op_single_bit_force_one);
  endfunction : is_bit_op

  function automatic logic is_inverse_op(input bls_op_t op);
    is_inverse_op = (op == op_carry_and_inverted_bit) ||
                    (op == op_carry_or_inverted_bit) ||
                    (op == op_carry_xor_inverted_bit) ||
                    (op == op_carry_load_inverted_bit) ||
                    (op == op_carry_store_inverted);
  endfunction : is_inverse_op

  function automatic logic writes_operand(input bls_op_t op);
    writes_operand = (op <= op_single_bit_toggle) ||
                     (op == op_carry_store_to_bit) ||
                     (op == op_carry_store_inverted);
  endfunction : writes_operand

  // ************************************
  // state and latched command
  // ************************************
  bls_state_t state_reg;
  bls_state_t state_next;
  bls_op_t op_reg;
  logic [`BLS_IDX_W-1:0] dst_idx_reg;
  logic [`BLS_IDX_W-1:0] src_idx_reg;
  logic use_imm_reg;
  logic [`BLS_DATA_W-1:0] imm_reg;
  logic [`BLS_BIT_W-1:0] bit_imm_reg;
  logic bit_from_reg_reg;
  logic to_mem_reg;
  logic [`BLS_ADDR_W-1:0] addr_reg;
  logic [`BLS_DATA_W-1:0] mem_byte_reg;
  logic [`BLS_DATA_W-1:0] wdata_reg;
  logic [`BLS_DATA_W-1:0] result_reg;
  logic done_reg;
  logic carry_reg;
  logic zero_reg;
  logic [`BLS_DATA_W-1:0] gpr_a;
  logic [`BLS_DATA_W-1:0] gpr_b;
  logic [`BLS_DATA_W-1:0] opnd;
  logic [`BLS_DATA_W-1:0] src;
  logic [`BLS_BIT_W-1:0] bitn;
  logic sel_bit;
  logic [`BLS_DATA_W-1:0] res;
  logic res_we;
  logic c_next;
  logic c_we;
  logic z_next;
  logic z_we;
  logic exec;
  logic gpr_we;

  bls_gpr_file u_gpr (
    .core_clk(core_clk),
    .rst(rst),
    .rd_a_idx(dst_idx_reg),
    .rd_b_idx(src_idx_reg),
    .rd_a_data(gpr_a),
    .rd_b_data(gpr_b),
    .wr_en(gpr_we),
    .wr_idx(dst_idx_reg),
    .wr_data(res)
  );

  assign cmd_ready = (state_reg == st_idle);
  assign exec = (state_reg == st_execute);
  assign mem_rd_req = (state_reg == st_mem_read);
  assign mem_wr_req = (state_reg == st_mem_write);
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign done = done_reg;
  assign result_data = result_reg;
  assign carry_flag = carry_reg;
  assign zero_flag = zero_reg;
  assign gpr_we = exec && res_we && !to_mem_reg;

  // ************************************
  // command capture
  // ************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      op_reg <= op_and;
      dst_idx_reg <= '0;
      src_idx_reg <= '0;
      use_imm_reg <= 1'b0;
      imm_reg <= `BLS_BYTE_RST;
      bit_imm_reg <= '0;
      bit_from_reg_reg <= 1'b0;
      to_mem_reg <= 1'b0;
      addr_reg <= `BLS_ADDR_RST;
    end
    else if (cmd_valid && cmd_ready)
    begin
      op_reg <= cmd_op;
      dst_idx_reg <= cmd_dst_idx;
      src_idx_reg <= cmd_src_idx;
      use_imm_reg <= cmd_use_imm;
      imm_reg <= cmd_imm;
      bit_imm_reg <= cmd_bit_imm;
      bit_from_reg_reg <= cmd_bit_from_reg && !is_inverse_op(cmd_op);
      to_mem_reg <= cmd_to_mem && is_bit_op(cmd_op);
      addr_reg <= cmd_mem_addr;
    end
  end

  // ************************************
  // sequencer
  // ************************************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_idle:
        if (cmd_valid)
        begin
          state_next = st_reg_read;
        end
      st_reg_read:
        state_next = to_mem_reg ? st_mem_read : st_execute;
      st_mem_read:
        if (mem_rdy)
        begin
          state_next = st_execute;
        end
      st_execute:
        if (to_mem_reg && writes_operand(op_reg))
        begin
          state_next = st_mem_write;
        end
        else
        begin
          state_next = st_idle;
        end
      st_mem_write:
        if (mem_rdy)
        begin
          state_next = st_idle;
        end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= st_idle;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ************************************
  // memory byte read and write back
  // ************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_byte_reg <= `BLS_BYTE_RST;
      wdata_reg <= `BLS_BYTE_RST;
    end
    else
    begin
      if (mem_rd_req && mem_rdy)
      begin
        mem_byte_reg <= mem_rdata;
      end
      if (exec && to_mem_reg && res_we)
      begin
        wdata_reg <= res;
      end
    end
  end

  // ************************************
  // operand selection
  // ************************************
  assign opnd = to_mem_reg ? mem_byte_reg : gpr_a;
  assign src = use_imm_reg ? imm_reg : gpr_b;
  assign bitn = bit_from_reg_reg ? gpr_b[`BLS_BIT_W-1:0] : bit_imm_reg;
  assign sel_bit = opnd[bitn];

  // ************************************
  // datapath
  // ************************************
  always_comb
  begin
    res = opnd;
    res_we = 1'b1;
    c_next = carry_reg;
    c_we = 1'b0;
    z_next = zero_reg;
    z_we = 1'b0;
    unique case (op_reg)
      op_and: res = opnd & src;
      op_or: res = opnd | src;
      op_xor: res = opnd ^ src;
      op_not: res = ~opnd;
      op_arith_left_shift, op_logic_left_shift:
      begin
        res = {opnd[6:0], 1'b0};
        c_next = opnd[7];
        c_we = 1'b1;
      end
      op_arith_right_shift:
      begin
        res = {opnd[7], opnd[7:1]};
        c_next = opnd[0];
        c_we = 1'b1;
      end
      op_logic_right_shift:
      begin
        res = {1'b0, opnd[7:1]};
        c_next = opnd[0];
        c_we = 1'b1;
      end
      op_rotate_left_plain:
      begin
        res = {opnd[6:0], opnd[7]};
        c_next = opnd[7];
        c_we = 1'b1;
      end
      op_rotate_right_plain:
      begin
        res = {opnd[0], opnd[7:1]};
        c_next = opnd[0];
        c_we = 1'b1;
      end
      op_rotate_left_via_carry:
      begin
        res = {opnd[6:0], carry_reg};
        c_next = opnd[7];
        c_we = 1'b1;
      end
      op_rotate_right_via_carry:
      begin
        res = {carry_reg, opnd[7:1]};
        c_next = opnd[0];
        c_we = 1'b1;
      end
      op_single_bit_force_one: res = opnd | bit_mask(bitn);
      op_single_bit_force_zero: res = opnd & ~bit_mask(bitn);
      op_single_bit_toggle: res = opnd ^ bit_mask(bitn);
      op_single_bit_probe:
      begin
        res_we = 1'b0;
        z_next = ~sel_bit;
        z_we = 1'b1;
      end
      op_carry_store_to_bit:
        res = sel_bit != carry_reg ? opnd ^ bit_mask(bitn) : opnd;
      op_carry_store_inverted:
        res = sel_bit == carry_reg ? opnd ^ bit_mask(bitn) : opnd;
      default:
      begin
        res_we = 1'b0;
        c_we = 1'b1;
        unique case (op_reg)
          op_carry_and_bit: c_next = carry_reg & sel_bit;
          op_carry_and_inverted_bit: c_next = carry_reg & ~sel_bit;
          op_carry_or_bit: c_next = carry_reg | sel_bit;
          op_carry_or_inverted_bit: c_next = carry_reg | ~sel_bit;
          op_carry_xor_bit: c_next = carry_reg ^ sel_bit;
          op_carry_xor_inverted_bit: c_next = carry_reg ^ ~sel_bit;
          op_carry_load_from_bit: c_next = sel_bit;
          default: c_next = ~sel_bit;
        endcase
      end
    endcase
  end

  // ************************************
  // flags, result and completion
  // ************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      carry_reg <= `BLS_CARRY_RST;
      zero_reg <= `BLS_ZERO_RST;
    end
    else if (exec)
    begin
      if (c_we)
      begin
        carry_reg <= c_next;
      end
      if (z_we)
      begin
        zero_reg <= z_next;
      end
    end
    else if (flag_load)
    begin
      carry_reg <= flag_c_load_val;
      zero_reg <= flag_z_load_val;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      result_reg <= `BLS_BYTE_RST;
      done_reg <= 1'b0;
    end
    else
    begin
      if (exec)
      begin
        result_reg <= res;
      end
      done_reg <= (exec && !(to_mem_reg && writes_operand(op_reg))) ||
                  (mem_wr_req && mem_rdy);
    end
  end

  // ************************************
  // checks
  // ************************************
  a_logic_and: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_and |=> result_data == ($past(opnd) & $past(src)))
    else $error("and result wrong");
  a_not_value: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_not |=> result_data == ~$past(opnd))
    else $error("complement result wrong");
  a_arith_right: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_arith_right_shift |=>
      result_data[7:6] == {2{$past(opnd[7])}} && carry_flag == $past(opnd[0]))
    else $error("arithmetic right shift wrong");
  a_logic_right: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_logic_right_shift |=>
      result_data == {1'b0, $past(opnd[7:1])})
    else $error("logical right shift wrong");
  a_rotate_plain: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_rotate_left_plain |=>
      result_data[0] == carry_flag && carry_flag == $past(opnd[7]))
    else $error("plain rotate wrong");
  a_rotate_carry: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_rotate_right_via_carry |=>
      result_data[7] == $past(carry_flag) && carry_flag == $past(opnd[0]))
    else $error("rotate through carry wrong");
  a_shift_carry: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_logic_left_shift |=>
      carry_flag == $past(opnd[7]) && result_data[0] == 1'b0)
    else $error("shift carry or fill wrong");
  a_force_one: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_single_bit_force_one |=>
      result_data == ($past(opnd) | (8'h01 << $past(bitn))))
    else $error("force one wrong");
  a_force_zero: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_single_bit_force_zero |=>
      result_data == ($past(opnd) & ~(8'h01 << $past(bitn))))
    else $error("force zero wrong");
  a_probe_zero: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_single_bit_probe |=>
      zero_flag == !$past(sel_bit) && !mem_wr_req)
    else $error("probe zero flag wrong");
  a_inverse_imm: assert property (@(posedge core_clk) disable iff (rst)
    exec && is_inverse_op(op_reg) |-> bitn == bit_imm_reg)
    else $error("inverse op took register bit");
  a_carry_xor: assert property (@(posedge core_clk) disable iff (rst)
    exec && op_reg == op_carry_xor_bit |=>
      carry_flag == ($past(carry_flag) ^ $past(sel_bit)))
    else $error("carry xor wrong");
  a_mem_rmw: assert property (@(posedge core_clk) disable iff (rst)
    mem_rd_req && mem_rdy && writes_operand(op_reg) |=>
      ##1 mem_wr_req && mem_addr == $past(mem_addr, 2))
    else $error("memory write back missing");
endmodule : bls_unit

// ### bls_unit_test.sv
`timescale 1ns/10ps
`include "bls_defs.svh"
module bls_unit_test
  import bls_pkg::*;
;
  // ****************************************
  // signals and design
  // ****************************************
  localparam int LIMIT = 20000;
  localparam logic [15:0] ADDR = 16'h3C5A;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready, done, carry_flag, zero_flag, mem_rd_req, mem_wr_req;
  bls_op_t cmd_op = op_and;
  logic [2:0] cmd_dst_idx = 3'h0, cmd_src_idx = 3'h0, cmd_bit_imm = 3'h0;
  logic cmd_use_imm = 1'b0, cmd_bit_from_reg = 1'b0, cmd_to_mem = 1'b0;
  logic [7:0] cmd_imm = 8'h00, result_data, mem_wdata, mem_rdata = 8'h00;
  logic [15:0] cmd_mem_addr = ADDR, mem_addr, last_addr;
  logic flag_load = 1'b0, flag_c_load_val = 1'b0, flag_z_load_val = 1'b0;
  logic mem_rdy = 1'b0, rd_seen = 1'b0, wr_seen = 1'b0;
  logic [7:0] mem_byte = 8'h00;
  int bad_count = 0, checks_done = 0, cycles = 0, wcnt = 0, mem_wait = 0;
  int rd_cnt = 0, wr_cnt = 0;

  `define CHK(got, exp) \
    begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
        bad_count++; \
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      end \
    end

  always #50 core_clk = ~core_clk;

  bls_unit uut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_dst_idx(cmd_dst_idx),
    .cmd_src_idx(cmd_src_idx), .cmd_use_imm(cmd_use_imm),
    .cmd_imm(cmd_imm), .cmd_bit_imm(cmd_bit_imm),
    .cmd_bit_from_reg(cmd_bit_from_reg), .cmd_to_mem(cmd_to_mem),
    .cmd_mem_addr(cmd_mem_addr), .done(done), .result_data(result_data),
    .flag_load(flag_load), .flag_c_load_val(flag_c_load_val),
    .flag_z_load_val(flag_z_load_val), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .mem_rd_req(mem_rd_req),
    .mem_wr_req(mem_wr_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_rdy(mem_rdy));

  // ****************************************
  // memory byte responder
  // ****************************************
  always @(negedge core_clk)
  begin
    rd_seen = (mem_rd_req === 1'b1);
    wr_seen = (mem_wr_req === 1'b1);
    if (mem_rdy && wr_seen)
    begin
      mem_byte = mem_wdata;
      wr_cnt++;
      last_addr = mem_addr;
    end
    if (mem_rdy && rd_seen)
    begin
      rd_cnt++;
      last_addr = mem_addr;
    end
  end

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if ((rd_seen || wr_seen) && !mem_rdy)
    begin
      if (wcnt >= mem_wait)
      begin
        mem_rdy <= 1'b1;
        mem_rdata <= rd_seen ? mem_byte : ~mem_byte;
        wcnt <= 0;
      end
      else
        wcnt <= wcnt + 1;
    end
    else
    begin
      mem_rdy <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    if (cycles == LIMIT)
    begin
      bad_count++;
      finish_test();
    end
  end

  // ****************************************
  // shared tasks and expectations
  // ****************************************
  task automatic cmd(input bls_op_t op, input logic [2:0] d, s,
    input logic ui, input logic [7:0] im, input logic [2:0] b,
    input logic br, tm);
    int n;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_dst_idx <= d;
    cmd_src_idx <= s;
    cmd_use_imm <= ui;
    cmd_imm <= im;
    cmd_bit_imm <= b;
    cmd_bit_from_reg <= br;
    cmd_to_mem <= tm;
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (done !== 1'b1 && n < 60);
    if (n >= 60)
      bad_count++;
  endtask : cmd

  task automatic ld(input logic [2:0] d, input logic [7:0] v);
    cmd(op_and, d, 3'h0, 1'b1, 8'h00, 3'h0, 1'b0, 1'b0);
    cmd(op_or, d, 3'h0, 1'b1, v, 3'h0, 1'b0, 1'b0);
    `CHK(result_data, v)
  endtask : ld

  task automatic set_flags(input logic c, z);
    @(posedge core_clk);
    flag_load <= 1'b1;
    flag_c_load_val <= c;
    flag_z_load_val <= z;
    @(posedge core_clk);
    flag_load <= 1'b0;
  endtask : set_flags

  function automatic logic [8:0] exp_shift(bls_op_t op, logic [7:0] v,
    logic c);
    case (op)
      op_arith_left_shift, op_logic_left_shift: return {v[7], v[6:0], 1'b0};
      op_arith_right_shift: return {v[0], v[7], v[7:1]};
      op_logic_right_shift: return {v[0], 1'b0, v[7:1]};
      op_rotate_left_plain: return {v[7], v[6:0], v[7]};
      op_rotate_right_plain: return {v[0], v[0], v[7:1]};
      op_rotate_left_via_carry: return {v[7], v[6:0], c};
      default: return {v[0], c, v[7:1]};
    endcase
  endfunction : exp_shift

  function automatic logic [9:0] exp_bit(bls_op_t op, logic [7:0] v,
    logic c, z, logic [2:0] b, logic inv);
    logic [7:0] r;
    logic x, nc, nz;
    r = v;
    nc = c;
    nz = z;
    x = v[b] ^ inv;
    case (op)
      op_single_bit_force_one: r[b] = 1'b1;
      op_single_bit_force_zero: r[b] = 1'b0;
      op_single_bit_toggle: r[b] = ~v[b];
      op_single_bit_probe: nz = ~v[b];
      op_carry_and_bit, op_carry_and_inverted_bit: nc = c & x;
      op_carry_or_bit, op_carry_or_inverted_bit: nc = c | x;
      op_carry_xor_bit, op_carry_xor_inverted_bit: nc = c ^ x;
      op_carry_load_from_bit, op_carry_load_inverted_bit: nc = x;
      op_carry_store_to_bit, op_carry_store_inverted: r[b] = c ^ inv;
      default: ;
    endcase
    return {nz, nc, r};
  endfunction : exp_bit

  task automatic one_bit(input bls_op_t op, input logic [7:0] v,
    input logic c, input logic [2:0] bi, bv, input logic br, tm,
    input int w);
    logic [9:0] e;
    logic inv, wr;
    inv = (op >= op_carry_and_bit) && op[0];
    e = exp_bit(op, v, c, v[0], (br && !inv) ? bv : bi, inv);
    wr = (op <= op_single_bit_toggle) || (op >= op_carry_store_to_bit);
    if (tm)
      mem_byte = v;
    else
      ld(3'h1, v);
    ld(3'h3, {5'h15, bv});
    set_flags(c, v[0]);
    rd_cnt = 0;
    wr_cnt = 0;
    mem_wait = w;
    cmd(op, 3'h1, 3'h3, 1'b0, 8'h00, bi, br, tm);
    `CHK(result_data, e[7:0])
    `CHK(carry_flag, e[8])
    `CHK(zero_flag, e[9])
    if (tm)
    begin
      `CHK(rd_cnt, 1)
      `CHK(wr_cnt, int'(wr))
      `CHK(mem_byte, e[7:0])
      `CHK(last_addr, ADDR)
    end
  endtask : one_bit

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_logic();
    ld(3'h1, 8'h5A);
    ld(3'h2, 8'h3C);
    cmd(op_and, 3'h1, 3'h2, 1'b0, 8'hFF, 3'h0, 1'b0, 1'b0);
    `CHK(result_data, 8'h18)
    cmd(op_or, 3'h1, 3'h2, 1'b1, 8'hC1, 3'h0, 1'b0, 1'b0);
    `CHK(result_data, 8'hD9)
    cmd(op_xor, 3'h1, 3'h2, 1'b0, 8'h00, 3'h0, 1'b0, 1'b0);
    `CHK(result_data, 8'hE5)
    cmd(op_xor, 3'h1, 3'h2, 1'b1, 8'hFF, 3'h0, 1'b0, 1'b0);
    `CHK(result_data, 8'h1A)
    cmd(op_not, 3'h1, 3'h2, 1'b0, 8'h00, 3'h0, 1'b0, 1'b0);
    `CHK(result_data, 8'hE5)
    cmd(op_or, 3'h2, 3'h0, 1'b1, 8'h00, 3'h0, 1'b0, 1'b0);
    `CHK(result_data, 8'h3C)
    $display("test logic finished");
  endtask : t_logic

  task automatic t_shift();
    logic [8:0] e;
    bls_op_t op;
    logic [7:0] v;
    for (int k = 0; k < 16; k++)
    begin
      op = bls_op_t'(5'(4 + k % 8));
      v = (k < 8) ? 8'h96 : 8'h69;
      e = exp_shift(op, v, k[0] ^ k[3]);
      ld(3'h1, v);
      set_flags(k[0] ^ k[3], 1'b0);
      cmd(op, 3'h1, 3'h0, 1'b0, 8'h00, 3'h0, 1'b0, 1'b0);
      `CHK(result_data, e[7:0])
      `CHK(carry_flag, e[8])
      cmd(op_or, 3'h1, 3'h0, 1'b1, 8'h00, 3'h0, 1'b0, 1'b0);
      `CHK(result_data, e[7:0])
    end
    $display("test shift finished");
  endtask : t_shift

  task automatic t_bits();
    logic [2:0] b;
    for (int o = 12; o < 26; o++)
      for (int k = 0; k < 8; k++)
      begin
        b = 3'(k * 3 + o);
        if (o < 16)
          one_bit(bls_op_t'(5'(o)), k[1] ? 8'h5A : 8'hA5, k[2],
            k[0] ? ~b : b, b, k[0], 1'b0, 0);
        else if (k < 4)
          one_bit(bls_op_t'(5'(o)), 8'h4D, k[0], b, ~b, k != 2, 1'b0, 0);
      end
    $display("test bits finished");
  endtask : t_bits

  task automatic t_mem();
    for (int o = 12; o < 26; o++)
      for (int w = 0; w < 4; w += 3)
        one_bit(bls_op_t'(5'(o)), 8'hC3, w != 0, 3'(o + w), ~3'(o), 1'b0,
          1'b1, w);
    $display("test memory finished");
  endtask : t_mem

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_logic();
    t_shift();
    t_bits();
    t_mem();
    finish_test();
  end
endmodule : bls_unit_test
